/* File: channel_select_isolation_ctrl.sv */
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
module channel_select_isolation_ctrl
	import switch_ctrl_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
	parameter int DIP_LEN      = DIP_CYCLES,
	parameter int BLINK_LEN    = BLINK_CYCLES,
	parameter int BLINK_HALF   = BLINK_HALF_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [3:0]  btn,
	input  wire logic        mouse_req,
	input  wire logic [1:0]  mouse_ch,
	input  wire logic        freeze_btn,
	input  wire logic        default_sw,
	input  wire logic        self_test_done,
	input  wire logic        self_test_pass,
	input  wire logic        tamper,
	input  wire logic        dev_valid,
	input  wire logic [7:0]  dev_class,
	input  wire logic [7:0]  dev_subclass,
	input  wire logic [7:0]  dev_protocol,
	input  wire logic [15:0] dev_vid,
	input  wire logic [15:0] dev_pid,
	input  wire logic [31:0] dev_serial,
	input  wire logic [15:0] dev_ccid_rev,
	input  wire logic [15:0] dev_usb_ver,
	input  wire logic        dev_bus_powered,
	output logic [2:0]       km_sel,
	output logic [2:0]       audio_sel,
	output logic             audio_relay_on,
	output logic [2:0]       auth_sel,
	output logic             auth_power_en,
	output logic             auth_discharge_on,
	output logic             dev_enable,
	output logic             dev_reject,
	output logic [3:0]       led_channel,
	output logic [3:0]       led_audio,
	output logic [3:0]       led_auth,
	output logic             led_freeze,
	output logic             selftest_restart
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] onehot_ch(input logic [2:0] ch);
		return (ch == ISO_POS) ? 4'h0 : (4'h1 << ch[1:0]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// front panel inputs
	logic [5:0]  raw_s1;
	logic [5:0]  raw_s2;
	logic [5:0]  stable;
	logic [5:0]  stable_d;
	logic [31:0] db_cnt;
	wire  [5:0]  press = stable & ~stable_d;

	// one shared settle counter: it restarts only when all synced inputs match the stable state again or when it takes a new stable state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_s1 <= 6'h00;
			raw_s2 <= 6'h00;
			stable <= 6'h00;
			stable_d <= 6'h00;
			db_cnt <= 32'h0000_0000;
		end else begin
			raw_s1 <= {default_sw, freeze_btn, btn};
			raw_s2 <= raw_s1;
			stable_d <= stable;
			if (raw_s2 == stable) begin
				db_cnt <= 32'h0000_0000;
			end else if (db_cnt >= 32'(DEBOUNCE_LEN - 1)) begin
				stable <= raw_s2;
				db_cnt <= 32'h0000_0000;
			end else begin
				db_cnt <= db_cnt + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// system state
	state_type   state;
	logic [31:0] blink_cnt;
	logic [31:0] half_cnt;
	logic        blink_phase;
	wire         normal = (state == ST_NORMAL);
	wire         blink_done = (state == ST_BLINK) && (blink_cnt >= 32'(BLINK_LEN - 1));
	wire         fact_clear = blink_done;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_POWERUP;
			selftest_restart <= 1'b0;
		end else begin
			selftest_restart <= blink_done;
			if (tamper) begin
				state <= ST_FAIL;
			end else begin
				unique case (state)
					ST_POWERUP: begin
						if (self_test_done) begin
							state <= self_test_pass ? ST_NORMAL : ST_FAIL;
						end
					end
					ST_NORMAL: begin
						if (press[5]) begin
							state <= ST_BLINK;
						end
					end
					ST_BLINK: begin
						if (blink_done) begin
							state <= ST_POWERUP;
						end
					end
					ST_FAIL: state <= ST_FAIL;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || state != ST_BLINK) begin
			blink_cnt <= 32'h0000_0000;
			half_cnt <= 32'h0000_0000;
			blink_phase <= 1'b1;
		end else begin
			blink_cnt <= blink_cnt + 32'h0000_0001;
			if (half_cnt >= 32'(BLINK_HALF - 1)) begin
				half_cnt <= 32'h0000_0000;
				blink_phase <= ~blink_phase;
			end else begin
				half_cnt <= half_cnt + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers reached over the bus
	logic        admin_session;
	logic        black_list;
	logic        cfg_mode;
	logic [31:0] dip_len;
	logic [5:0]  match_en;
	logic [23:0] match_cls;
	logic [31:0] match_id;
	logic [31:0] match_ser;
	logic [3:0]  block_mask;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  s_q;

	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	wire         do_write = aw_held && w_held && !bvalid;
	wire         wr_ctrl = do_write && (aw_q == CTRL_OFS);
	// filter settings only move while an administrator is logged in
	wire         wr_admin = do_write && admin_session;
	wire [31:0]  ctrl_val = {29'h0, black_list, 1'b0, admin_session};
	wire [31:0]  ctrl_new = merge(ctrl_val, w_q, s_q);
	wire [31:0]  cls_new = merge({8'h00, match_cls}, w_q, s_q);
	wire         wr_known = (aw_q == CTRL_OFS) || (aw_q == STATUS_OFS) || (aw_q == DIP_OFS)
		|| (aw_q == MATCH_EN_OFS) || (aw_q == MATCH_CLS_OFS) || (aw_q == MATCH_ID_OFS)
		|| (aw_q == MATCH_SER_OFS) || (aw_q == BLOCK_OFS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			s_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_q <= wdata;
				s_q <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// credentials and log live elsewhere; only switch settings return to defaults
	always_ff @(posedge aclk) begin
		if (!aresetn || fact_clear) begin
			admin_session <= 1'b0;
			black_list <= 1'b0;
			cfg_mode <= 1'b0;
			dip_len <= 32'(DIP_LEN);
			match_en <= 6'h00;
			match_cls <= 24'h00_0000;
			match_id <= 32'h0000_0000;
			match_ser <= 32'h0000_0000;
			block_mask <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				admin_session <= ctrl_new[CTRL_ADMIN];
				if (admin_session) begin
					black_list <= ctrl_new[CTRL_BLACK];
				end
				if (ctrl_new[CTRL_ADMIN] && s_q[0] && w_q[CTRL_COMMIT]) begin
					cfg_mode <= 1'b1;
				end
			end
			if (wr_admin && aw_q == DIP_OFS) begin
				dip_len <= merge(dip_len, w_q, s_q);
			end
			if (wr_admin && aw_q == MATCH_EN_OFS) begin
				match_en <= w_q[5:0] & {6{s_q[0]}} | match_en & ~{6{s_q[0]}};
			end
			if (wr_admin && aw_q == MATCH_CLS_OFS) begin
				match_cls <= cls_new[23:0];
			end
			if (wr_admin && aw_q == MATCH_ID_OFS) begin
				match_id <= merge(match_id, w_q, s_q);
			end
			if (wr_admin && aw_q == MATCH_SER_OFS) begin
				match_ser <= merge(match_ser, w_q, s_q);
			end
			if (wr_admin && aw_q == BLOCK_OFS && s_q[0]) begin
				block_mask <= w_q[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel selection
	logic [2:0]  km_target;
	logic [2:0]  audio_target;
	logic [2:0]  auth_target;
	logic        freeze_on;
	logic        dip_active;
	logic [31:0] dip_cnt;
	logic [2:0]  btn_ch;
	always_comb begin
		btn_ch = ISO_POS;
		for (int i = 3; i >= 0; i--) begin
			if (press[i]) begin
				btn_ch = 3'(i);
			end
		end
	end
	// connected computers have no path to request a change
	wire         sel_req = normal && (btn_ch != ISO_POS || mouse_req);
	wire [2:0]   req_ch = (btn_ch != ISO_POS) ? btn_ch : {1'b0, mouse_ch};
	wire [2:0]   next_km = !normal ? ISO_POS : (km_target == ISO_POS) ? FIRST_CH
		: sel_req ? req_ch : km_target;
	wire [2:0]   next_follow = freeze_on ? audio_target : next_km;
	wire         auth_change = (next_follow != auth_target) && normal && !dip_active;
	wire         dip_end = dip_active && (dip_cnt + 32'h0000_0001 >= dip_len);
	wire         blocked = cfg_mode && (auth_target != ISO_POS) && block_mask[auth_target[1:0]];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			km_target <= ISO_POS;
			audio_target <= ISO_POS;
			auth_target <= ISO_POS;
			freeze_on <= 1'b0;
			dip_active <= 1'b0;
			dip_cnt <= 32'h0000_0000;
		end else begin
			km_target <= next_km;
			audio_target <= next_follow;
			if (!normal) begin
				auth_target <= ISO_POS;
			end else if (auth_change) begin
				auth_target <= next_follow;
			end
			freeze_on <= normal && (freeze_on ^ press[4]);
			if (auth_change && auth_target != ISO_POS) begin
				dip_active <= 1'b1;
				dip_cnt <= 32'h0000_0000;
			end else if (!normal || dip_end) begin
				dip_active <= 1'b0;
			end else if (dip_active) begin
				dip_cnt <= dip_cnt + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// device qualification
	wire fixed_ok = (dev_class == SMARTCARD_CLASS) && dev_bus_powered
		&& (dev_ccid_rev == CCID_REV_A || dev_ccid_rev == CCID_REV_B);
	wire usb_ok = (dev_usb_ver >= USB_VER_MIN) && (dev_usb_ver <= USB_VER_MAX);
	wire [5:0] field_eq = {dev_serial == match_ser, dev_vid == match_id[15:0],
		dev_pid == match_id[31:16], dev_protocol == match_cls[23:16],
		dev_subclass == match_cls[15:8], dev_class == match_cls[7:0]};
	wire list_hit = (match_en != 6'h00) && (&(field_eq | ~match_en));
	// a white entry widens the default, a black entry narrows it
	wire cfg_ok = usb_ok && (black_list ? (fixed_ok && !list_hit) : (fixed_ok || list_hit));
	wire dev_accept = cfg_mode ? cfg_ok : fixed_ok;
	wire [2:0] next_auth = (!normal || dip_active || blocked) ? ISO_POS : auth_target;

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	wire show = normal || (state == ST_BLINK && blink_phase);
	wire [3:0] all_on = {4{state == ST_BLINK && blink_phase}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			km_sel <= ISO_POS;
			audio_sel <= ISO_POS;
			auth_sel <= ISO_POS;
			audio_relay_on <= 1'b0;
			auth_power_en <= 1'b0;
			auth_discharge_on <= 1'b0;
			dev_enable <= 1'b0;
			dev_reject <= 1'b0;
			led_channel <= 4'h0;
			led_audio <= 4'h0;
			led_auth <= 4'h0;
			led_freeze <= 1'b0;
		end else begin
			km_sel <= km_target;
			audio_sel <= normal ? audio_target : ISO_POS;
			auth_sel <= next_auth;
			audio_relay_on <= normal;
			auth_power_en <= normal && !dip_active;
			auth_discharge_on <= dip_active;
			dev_enable <= dev_valid && dev_accept && (next_auth != ISO_POS);
			dev_reject <= dev_valid && !dev_accept;
			// no dimming path exists: lit whenever the unit is operative
			led_channel <= normal ? onehot_ch(km_target) : all_on;
			led_audio <= normal ? onehot_ch(audio_target) : all_on;
			led_auth <= normal ? onehot_ch(auth_target) : all_on;
			led_freeze <= show && (freeze_on || !normal);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read side
	wire [31:0] status_val = {13'h0, km_target, 1'b0, auth_target, 1'b0, audio_target,
		dev_accept, dip_active, freeze_on, cfg_mode, state};
	wire [31:0] rd_val = (araddr == CTRL_OFS) ? ctrl_val
		: (araddr == STATUS_OFS) ? status_val
		: (araddr == DIP_OFS) ? dip_len
		: (araddr == MATCH_EN_OFS) ? {26'h0, match_en}
		: (araddr == MATCH_CLS_OFS) ? {8'h00, match_cls}
		: (araddr == MATCH_ID_OFS) ? match_id
		: (araddr == MATCH_SER_OFS) ? match_ser
		: (araddr == BLOCK_OFS) ? {28'h0, block_mask} : 32'h0000_0000;
	wire rd_known = (araddr == CTRL_OFS) || (araddr == STATUS_OFS) || (araddr == DIP_OFS)
		|| (araddr == MATCH_EN_OFS) || (araddr == MATCH_CLS_OFS) || (araddr == MATCH_ID_OFS)
		|| (araddr == MATCH_SER_OFS) || (araddr == BLOCK_OFS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

/* File: switch_ctrl_pkg.sv */
package switch_ctrl_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int DIP_MS = 100;
	localparam int DIP_CYCLES = CLK_HZ / 1000 * DIP_MS;
	localparam int BLINK_MS = 2000;
	localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam logic [2:0] ISO_POS = 3'h4;
	localparam logic [2:0] FIRST_CH = 3'h0;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DIP_OFS = 8'h08;
	localparam logic [7:0] MATCH_EN_OFS = 8'h0C;
	localparam logic [7:0] MATCH_CLS_OFS = 8'h10;
	localparam logic [7:0] MATCH_ID_OFS = 8'h14;
	localparam logic [7:0] MATCH_SER_OFS = 8'h18;
	localparam logic [7:0] BLOCK_OFS = 8'h1C;
	localparam int CTRL_ADMIN = 0;
	localparam int CTRL_COMMIT = 1;
	localparam int CTRL_BLACK = 2;
	localparam logic [7:0] SMARTCARD_CLASS = 8'h0B;
	localparam logic [15:0] CCID_REV_A = 16'h0110;
	localparam logic [15:0] CCID_REV_B = 16'h0100;
	localparam logic [15:0] USB_VER_MIN = 16'h0110;
	localparam logic [15:0] USB_VER_MAX = 16'h03FF;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [3:0] {
		ST_POWERUP = 4'b0001,
		ST_NORMAL  = 4'b0010,
		ST_BLINK   = 4'b0100,
		ST_FAIL    = 4'b1000
	} state_type;
endpackage

/* File: ctrl_chk.sv */
module ctrl_chk
	import switch_ctrl_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       tamper,
	input wire logic       self_test_done,
	input wire logic [2:0] km_sel,
	input wire logic [2:0] audio_sel,
	input wire logic [2:0] auth_sel,
	input wire logic       audio_relay_on,
	input wire logic       auth_power_en,
	input wire logic       auth_discharge_on,
	input wire logic       dev_enable,
	input wire logic       dev_reject,
	input wire logic [3:0] led_channel,
	input wire logic [3:0] led_audio,
	input wire logic [3:0] led_auth,
	input wire logic       led_freeze
);
	logic seen_done;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// first verdict ends the dark phase; later restarts are judged by the bench
	always_ff @(posedge aclk) begin
		if (!aresetn)
			seen_done <= 1'b0;
		else if (self_test_done)
			seen_done <= 1'b1;
	end
	////////////////////////////////////////
	powerup_iso_a: assert property (
		!seen_done |-> km_sel == ISO_POS && audio_sel == ISO_POS && auth_sel == ISO_POS
			&& led_channel == 4'h0 && !audio_relay_on)
		else $error("selection shown before self-test verdict");
	fault_iso_a: assert property (
		tamper |-> ##[1:4] (!audio_relay_on && auth_sel == ISO_POS && !auth_power_en))
		else $error("tamper did not isolate audio and auth paths");
	dip_power_a: assert property (
		auth_discharge_on |-> !auth_power_en)
		else $error("discharge on while port powered");
	dip_sel_a: assert property (
		auth_discharge_on |-> auth_sel == ISO_POS)
		else $error("auth path connected during power dip");
	dip_length_a: assert property (
		$rose(auth_discharge_on) |-> auth_discharge_on[*8] ##1 !auth_discharge_on)
		else $error("power dip length wrong");
	led_onehot_a: assert property (
		audio_relay_on |-> $onehot0(led_audio) && $onehot0(led_auth) && $onehot0(led_channel))
		else $error("more than one channel indicated");
	freeze_hold_a: assert property (
		$past(led_freeze && audio_relay_on) && audio_relay_on |-> $stable(audio_sel)
			&& $stable(auth_sel))
		else $error("selection moved while frozen");
	dev_excl_a: assert property (
		dev_enable |-> !dev_reject)
		else $error("device enabled and rejected at once");

	cover property ($rose(auth_discharge_on));
	cover property (led_freeze && audio_relay_on);
	cover property (tamper && audio_relay_on);
endmodule

bind channel_select_isolation_ctrl ctrl_chk chk (.aclk, .aresetn, .tamper, .self_test_done,
	.km_sel, .audio_sel, .auth_sel, .audio_relay_on, .auth_power_en, .auth_discharge_on,
	.dev_enable, .dev_reject, .led_channel, .led_audio, .led_auth, .led_freeze);

/* File: usb_dev_model.sv */
// kind 0/1: bus-powered smart-card reader at either revision, 2: self-powered, 3: storage
module usb_dev_model
	import switch_ctrl_pkg::*;
(
	input  wire logic [1:0] kind,
	output logic [7:0]      dev_class,
	output logic [7:0]      dev_subclass,
	output logic [7:0]      dev_protocol,
	output logic [15:0]     dev_vid,
	output logic [15:0]     dev_pid,
	output logic [31:0]     dev_serial,
	output logic [15:0]     dev_ccid_rev,
	output logic [15:0]     dev_usb_ver,
	output logic            dev_bus_powered
);
	assign dev_class       = (kind == 2'h3) ? 8'h08 : 8'h0B;
	assign dev_subclass    = 8'h00;
	assign dev_protocol    = 8'h00;
	// ids are arbitrary
	assign dev_vid         = 16'h1234;
	assign dev_pid         = 16'h5678;
	assign dev_serial      = 32'h0000_0001;
	assign dev_ccid_rev    = (kind == 2'h1) ? 16'h0100 : 16'h0110;
	assign dev_usb_ver     = 16'h0200;
	assign dev_bus_powered = (kind != 2'h2);
endmodule

/* File: channel_select_isolation_ctrl_bench.sv */
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD %0t got %0h expected %0h", $time, got, exp); end end
`define WAIT(c) begin int i; i = 0; do begin @(negedge aclk); i++; end \
	while (!(c) && i < 400); if (!(c)) begin miscompares++; \
	$display("BAD %0t wait timed out", $time); end end

module channel_select_isolation_ctrl_bench
	import switch_ctrl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DB = 4;
	localparam int DIP = 8;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, d;
	logic [3:0]  wstrb = 4'h0, btn = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        mouse_req = 1'b0, freeze_btn = 1'b0, default_sw = 1'b0, tamper = 1'b0;
	logic        self_test_done = 1'b0, self_test_pass = 1'b0, dev_valid = 1'b0;
	logic [1:0]  mouse_ch = 2'h0, kind = 2'h0, r, bresp, rresp;
	logic [31:0] rdata, dev_serial;
	logic [2:0]  km_sel, audio_sel, auth_sel;
	logic [3:0]  led_channel, led_audio, led_auth;
	logic [7:0]  dev_class, dev_subclass, dev_protocol;
	logic [15:0] dev_vid, dev_pid, dev_ccid_rev, dev_usb_ver;
	logic        awready, wready, bvalid, arready, rvalid, audio_relay_on, auth_power_en;
	logic        auth_discharge_on, dev_enable, dev_reject, led_freeze, selftest_restart;
	logic        dev_bus_powered;
	int          total_checks = 0, miscompares = 0, dip_cycles = 0;

	channel_select_isolation_ctrl #(.DEBOUNCE_LEN(DB), .DIP_LEN(DIP), .BLINK_LEN(40),
		.BLINK_HALF(5)) uut (.*);
	usb_dev_model dev (.kind, .dev_class, .dev_subclass, .dev_protocol, .dev_vid, .dev_pid,
		.dev_serial, .dev_ccid_rev, .dev_usb_ver, .dev_bus_powered);

	always #10 aclk = ~aclk;
	always @(posedge aclk) if (auth_discharge_on === 1'b1) dip_cycles <= dip_cycles + 1;
	////////////////////////////////////////
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		`WAIT(awready && wready)
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		`WAIT(bvalid)
		`CHECK(bresp, RESP_OKAY)
		@(posedge aclk);
		bready  <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		`WAIT(arready)
		@(posedge aclk);
		arvalid <= 1'b0;
		`WAIT(rvalid)
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready  <= 1'b0;
	endtask
	// held well past the debounce window so one press is seen exactly once
	task automatic press(input logic [5:0] p);
		@(posedge aclk);
		{default_sw, freeze_btn, btn} <= p;
		repeat (DB + 6) @(posedge aclk);
		{default_sw, freeze_btn, btn} <= 6'h00;
		repeat (DB + 6) @(posedge aclk);
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		tamper  <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic t_powerup();
		repeat (5) @(negedge aclk);
		`CHECK(km_sel, ISO_POS)
		`CHECK(auth_sel, ISO_POS)
		`CHECK(led_channel, 4'h0)
		@(posedge aclk);
		self_test_pass <= 1'b1;
		self_test_done <= 1'b1;
		@(posedge aclk);
		self_test_done <= 1'b0;
		`WAIT(led_channel == 4'h1)
		repeat (4) @(negedge aclk);
		`CHECK(led_channel, 4'h1)
		`CHECK(audio_sel, FIRST_CH)
		`CHECK(led_auth, 4'h1)
		`CHECK(audio_relay_on, 1'b1)
	endtask
	task automatic t_switch();
		dip_cycles = 0;
		press(6'h04);
		`WAIT(auth_sel == 3'h2)
		repeat (2) @(negedge aclk);
		`CHECK(dip_cycles, DIP)
		`CHECK(km_sel, 3'h2)
		`CHECK(auth_power_en, 1'b1)
		`CHECK(led_audio, 4'h4)
		`CHECK(led_auth, 4'h4)
	endtask
	task automatic t_filter();
		for (int k = 0; k < 4; k++) begin
			@(posedge aclk);
			kind      <= k[1:0];
			dev_valid <= 1'b1;
			repeat (4) @(negedge aclk);
			`CHECK(dev_enable, k < 2)
			`CHECK(dev_reject, k >= 2)
		end
	endtask
	task automatic t_config();
		axi_wr(CTRL_OFS, 32'h0000_0002);
		axi_rd(STATUS_OFS);
		`CHECK(d[4], 1'b0)
		axi_rd(8'h40);
		`CHECK(r, RESP_SLVERR)
		`CHECK(d, 32'h0000_0000)
		axi_wr(CTRL_OFS, 32'h0000_0001);
		axi_wr(MATCH_EN_OFS, 32'h0000_0001);
		axi_wr(MATCH_CLS_OFS, 32'h0000_0008);
		axi_wr(CTRL_OFS, 32'h0000_0003);
		axi_rd(STATUS_OFS);
		`CHECK(d[4], 1'b1)
		`CHECK(d[18:16], 3'h2)
		repeat (4) @(negedge aclk);
		`CHECK(dev_enable, 1'b1)
		axi_wr(BLOCK_OFS, 32'h0000_0004);
		repeat (4) @(negedge aclk);
		`CHECK(auth_sel, ISO_POS)
		axi_wr(BLOCK_OFS, 32'h0000_0000);
		repeat (4) @(negedge aclk);
		`CHECK(auth_sel, 3'h2)
	endtask
	task automatic t_freeze();
		press(6'h10);
		`CHECK(led_freeze, 1'b1)
		@(posedge aclk);
		mouse_ch  <= 2'h3;
		mouse_req <= 1'b1;
		@(posedge aclk);
		mouse_req <= 1'b0;
		`WAIT(km_sel == 3'h3)
		repeat (DIP + 4) @(negedge aclk);
		`CHECK(km_sel, 3'h3)
		`CHECK(audio_sel, 3'h2)
		`CHECK(auth_sel, 3'h2)
		press(6'h10);
		repeat (DIP + 4) @(negedge aclk);
		`CHECK(led_freeze, 1'b0)
	endtask
	task automatic t_tamper();
		@(posedge aclk);
		tamper <= 1'b1;
		repeat (4) @(negedge aclk);
		`CHECK(audio_relay_on, 1'b0)
		`CHECK(auth_sel, ISO_POS)
		`CHECK(km_sel, ISO_POS)
		press(6'h01);
		`CHECK(km_sel, ISO_POS)
	endtask
	task automatic t_default();
		axi_wr(CTRL_OFS, 32'h0000_0003);
		axi_rd(STATUS_OFS);
		`CHECK(d[4], 1'b1)
		@(posedge aclk);
		default_sw <= 1'b1;
		`WAIT(led_channel == 4'hf)
		`CHECK(led_channel, 4'hf)
		// km_sel trails the blink indication by one register stage; auth_sel and audio_relay_on change with it
		@(negedge aclk);
		`CHECK(km_sel, ISO_POS)
		`CHECK(auth_sel, ISO_POS)
		`CHECK(audio_relay_on, 1'b0)
		@(posedge aclk);
		default_sw <= 1'b0;
		`WAIT(selftest_restart)
		repeat (3) @(negedge aclk);
		`CHECK(led_channel, 4'h0)
		axi_rd(STATUS_OFS);
		`CHECK(d[4], 1'b0)
		axi_rd(CTRL_OFS);
		`CHECK(d[0], 1'b0)
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		do_reset();
		t_powerup();
		t_switch();
		t_filter();
		t_config();
		t_freeze();
		t_tamper();
		do_reset();
		t_powerup();
		t_default();
		t_powerup();
		final_report();
	end
	// roughly sixty times the cycles the scenarios need
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		final_report();
	end
endmodule
